// file: hdl/isr_params.svh
// Constants for the serial register access slave.
`ifndef ISR_PARAMS_SVH
`define ISR_PARAMS_SVH
// Seven-bit bus address answered by the slave
`define ISR_SLAVE_ADDR 7'h0A
// Management-mode strap value that enables the slave
`define ISR_MODE_SERIAL 2'h2
// Bit clocks per byte before the acknowledge clock
`define ISR_BYTE_BITS 4'h8
// Index of the last byte of a 32-bit register
`define ISR_LAST_BYTE 2'h3
// Bus rates served, in kHz
`define ISR_STD_KHZ 100
`define ISR_FAST_KHZ 400
`endif

// file: hdl/isr_pkg.sv
// Types shared by the serial register access slave.
package isr_pkg;
	// Kind of access handed to the register side
	typedef enum logic [1:0] {
		ISR_OP_READ   = 2'h0,
		ISR_OP_WRITE  = 2'h1,
		ISR_OP_COMMIT = 2'h2
	} isr_op_t;

	// One register access: opcode, byte address, write data
	typedef struct packed {
		isr_op_t     op;
		logic [9:0]  addr;
		logic [31:0] wdata;
	} isr_req_t;

	// Link-side sequencer states
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_CTL  = 3'h1,
		ST_IDX  = 3'h2,
		ST_WR   = 3'h3,
		ST_ACK  = 3'h4,
		ST_TX   = 3'h5,
		ST_MACK = 3'h6,
		ST_IGN  = 3'h7
	} isr_state_t;
endpackage

// file: hdl/isr_top.sv
// Serial slave port giving an external host 32-bit access to system registers.
//
// Notes on behaviour
// - Slave runs only if the management-mode strap read 10b when it was caught once after reset.
// - Works at 100 kHz and 400 kHz bus rates.
// - Control byte is seven address bits msb first plus direction; address 0001010b.
// - Matching control byte is acknowledged; otherwise ignore everything until next start.
// - Direction 0: next byte is the register index, and it is acknowledged.
// - Start or stop after the index writes nothing but keeps the pointer.
// - Direction 1: shifting data begins right after the control acknowledge.
// - Index byte is a DWORD index; byte address appends two zero bits.
// - Bits go msb first; register goes out most significant byte first.
// - A read sends four bytes; single read ends with nack then stop.
// - Single read ending in nack on byte four leaves the pointer alone.
// - Ack on byte four advances pointer and sends the next register.
// - Pointer wraps to zero past its maximum.
// - In a burst the pointer advances for every register, the last included.
// - Nack on any of the first three bytes stops further bytes.
// - Unexpected start or stop stops transmission at once; ready for next sequence.
// - Register value is captured before each 32-bit read begins.
// - Read side effects apply only after all 32 bits went out.
// - A read ended early gets no side effect.
// - Unimplemented addresses read back as zero.
// - A write lands only after all 32 bits; short writes are dropped.
// - Bytes after the fourth write ack go to the next register, pointer wrapping.
`include "isr_params.svh"
`timescale 1ns/100ps
`default_nettype none

module isr_top (
	input  wire logic             REF_CLK,
	input  wire logic             RESET,
	input  wire logic             CLK_EN,
	input  wire logic             LINK_CLK,
	input  wire logic [1:0]       MGMT_MODE_STRAP,
	input  wire logic             SCL_I,
	input  wire logic             SDA_I,
	output var  logic             SDA_O,
	output var  logic             SDA_OE,
	output var  logic             SERIAL_ACTIVE,
	output var  isr_pkg::isr_req_t REG_REQ,
	output var  logic             REG_STB,
	input  wire logic             REG_ACK,
	input  wire logic [31:0]      REG_RDATA,
	input  wire logic             REG_HIT
);
	import isr_pkg::*;

	// ==========================================================
	// Reference domain: strap capture and register access
	// ==========================================================
	logic [1:0]  mode_m_q, mode_s_q;
	logic        strap_done_q, mode_en_q;
	logic [1:0]  warm_q;
	logic        rt_m_q, rt_s_q, rt_p_q;
	logic        busy_q, ack_tgl_q, stb_q;
	isr_req_t    reg_req_q;
	logic [31:0] rsp_q;
	isr_req_t    req_q;
	logic        req_tgl_q;
	wire         rt_edge = rt_s_q ^ rt_p_q;
	wire         rsp_take = busy_q & REG_ACK;
	wire  [31:0] rd_word = REG_HIT ? REG_RDATA : 32'h0000_0000;

	// Strap and toggle synchronisers
	always_ff @(posedge REF_CLK or posedge RESET) begin
		if (RESET) begin
			mode_m_q <= 2'h0;
			mode_s_q <= 2'h0;
			warm_q   <= 2'h0;
			rt_m_q   <= 1'b0;
			rt_s_q   <= 1'b0;
			rt_p_q   <= 1'b0;
		end else if (CLK_EN) begin
			mode_m_q <= MGMT_MODE_STRAP;
			mode_s_q <= mode_m_q;
			warm_q   <= {warm_q[0], 1'b1};
			rt_m_q   <= req_tgl_q;
			rt_s_q   <= rt_m_q;
			rt_p_q   <= rt_s_q;
		end
	end

	// Strap is caught once, after the sampler has filled, so later pin motion cannot toggle the port
	always_ff @(posedge REF_CLK or posedge RESET) begin
		if (RESET) begin
			strap_done_q <= 1'b0;
			mode_en_q    <= 1'b0;
		end else if (CLK_EN && !strap_done_q && warm_q[1] && rt_p_q == rt_s_q) begin
			strap_done_q <= 1'b1;
			mode_en_q    <= (mode_s_q == `ISR_MODE_SERIAL);
		end
	end

	// Request words are stable while their toggle is in flight, so sampling them here is safe
	always_ff @(posedge REF_CLK or posedge RESET) begin
		if (RESET) begin
			reg_req_q <= '0;
			stb_q     <= 1'b0;
			busy_q    <= 1'b0;
			ack_tgl_q <= 1'b0;
			rsp_q     <= 32'h0000_0000;
		end else if (CLK_EN) begin
			stb_q <= rt_edge;
			if (rt_edge) begin
				reg_req_q <= req_q;
				busy_q    <= 1'b1;
			end else if (rsp_take) begin
				busy_q    <= 1'b0;
				ack_tgl_q <= ~ack_tgl_q;
				if (reg_req_q.op == ISR_OP_READ) begin
					rsp_q <= rd_word;
				end
			end
		end
	end

	assign REG_REQ       = reg_req_q;
	assign REG_STB       = stb_q;
	assign SERIAL_ACTIVE = mode_en_q;

	property p_zero_fill;
		@(posedge REF_CLK) disable iff (RESET)
		(CLK_EN && rsp_take && !rt_edge && !REG_HIT && reg_req_q.op == ISR_OP_READ) |=> (rsp_q == 32'h0000_0000);
	endproperty
	a_zero_fill: assert property (p_zero_fill) else $error("unmapped read not zero");

	// ==========================================================
	// Link domain: pin sampling and bus sequencer
	// ==========================================================
	logic        lrst_m_q, lrst_q;
	logic        scl_m_q, scl_s_q, scl_p_q;
	logic        sda_m_q, sda_s_q, sda_p_q;
	logic        en_m_q, en_s_q, ce_m_q, ce_s_q;
	logic        ack_m_q, ack_s_q, ack_p_q;
	isr_state_t  st_q, st_d, nxt_q, nxt_d;
	logic [3:0]  cnt_q, cnt_d;
	logic [1:0]  bidx_q, bidx_d;
	logic [7:0]  sh_q, sh_d, ptr_q, ptr_d;
	logic [23:0] wbuf_q, wbuf_d;
	logic [31:0] tx_q, tx_d, pre_q;
	logic        mack_q, mack_d, burst_q, burst_d, oe_q, oe_d, sda_o_q;
	logic        req_fire;
	isr_req_t    req_d;

	// Reset reaches the link asynchronously but leaves it on a link edge
	always_ff @(posedge LINK_CLK or posedge RESET) begin
		if (RESET) begin
			lrst_m_q <= 1'b1;
			lrst_q   <= 1'b1;
		end else begin
			lrst_m_q <= 1'b0;
			lrst_q   <= lrst_m_q;
		end
	end

	// Two-stage samplers; the link clock far outruns 400 kHz so edges are never missed
	always_ff @(posedge LINK_CLK or posedge lrst_q) begin
		if (lrst_q) begin
			scl_m_q <= 1'b1;
			scl_s_q <= 1'b1;
			scl_p_q <= 1'b1;
			sda_m_q <= 1'b1;
			sda_s_q <= 1'b1;
			sda_p_q <= 1'b1;
			en_m_q  <= 1'b0;
			en_s_q  <= 1'b0;
			ce_m_q  <= 1'b0;
			ce_s_q  <= 1'b0;
			ack_m_q <= 1'b0;
			ack_s_q <= 1'b0;
			ack_p_q <= 1'b0;
		end else begin
			scl_m_q <= SCL_I;
			scl_s_q <= scl_m_q;
			scl_p_q <= scl_s_q;
			sda_m_q <= SDA_I;
			sda_s_q <= sda_m_q;
			sda_p_q <= sda_s_q;
			en_m_q  <= mode_en_q;
			en_s_q  <= en_m_q;
			ce_m_q  <= CLK_EN;
			ce_s_q  <= ce_m_q;
			ack_m_q <= ack_tgl_q;
			ack_s_q <= ack_m_q;
			ack_p_q <= ack_s_q;
		end
	end

	// Bus condition decode; clock comes only from the host
	wire scl_rise = scl_s_q & ~scl_p_q;
	wire scl_fall = ~scl_s_q & scl_p_q;
	wire bus_start = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
	wire bus_stop  = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
	wire go       = ce_s_q & en_s_q & ~bus_start & ~bus_stop;
	wire byte_end = scl_fall & (cnt_q == `ISR_BYTE_BITS);
	wire addr_hit = (sh_q[7:1] == `ISR_SLAVE_ADDR);
	wire last_byte = (bidx_q == `ISR_LAST_BYTE);
	wire [7:0] ptr_inc = ptr_q + 8'h01;
	wire ack_edge = ack_s_q ^ ack_p_q;

	// Sequencer next state
	always_comb begin
		st_d     = st_q;
		nxt_d    = nxt_q;
		cnt_d    = cnt_q;
		bidx_d   = bidx_q;
		sh_d     = sh_q;
		ptr_d    = ptr_q;
		wbuf_d   = wbuf_q;
		tx_d     = tx_q;
		mack_d   = mack_q;
		burst_d  = burst_q;
		oe_d     = oe_q;
		req_fire = 1'b0;
		req_d    = req_q;
		if (!en_s_q) begin
			st_d = ST_IDLE;
			oe_d = 1'b0;
		end else if (bus_start) begin
			st_d  = ST_CTL;
			cnt_d = 4'h0;
			oe_d  = 1'b0;
		end else if (bus_stop) begin
			st_d = ST_IDLE;
			oe_d = 1'b0;
		end else begin
			unique case (st_q)
				ST_IDLE, ST_IGN: begin
					oe_d = 1'b0;
				end
				ST_CTL, ST_IDX, ST_WR: begin
					if (scl_rise && cnt_q != `ISR_BYTE_BITS) begin
						sh_d  = {sh_q[6:0], sda_s_q};
						cnt_d = cnt_q + 4'h1;
					end else if (byte_end) begin
						cnt_d = 4'h0;
						st_d  = ST_ACK;
						oe_d  = 1'b1;
						if (st_q == ST_CTL) begin
							bidx_d  = 2'h0;
							burst_d = 1'b0;
							nxt_d   = sh_q[0] ? ST_TX : ST_IDX;
							if (!addr_hit) begin
								st_d = ST_IGN;
								oe_d = 1'b0;
							end else if (sh_q[0]) begin
								req_fire = 1'b1;
								req_d    = '{ISR_OP_READ, {ptr_q, 2'h0}, 32'h0000_0000};
							end
						end else if (st_q == ST_IDX) begin
							ptr_d  = sh_q;
							nxt_d  = ST_WR;
							bidx_d = 2'h0;
						end else begin
							nxt_d  = ST_WR;
							wbuf_d = {wbuf_q[15:0], sh_q};
							bidx_d = bidx_q + 2'h1;
							if (last_byte) begin
								req_fire = 1'b1;
								req_d    = '{ISR_OP_WRITE, {ptr_q, 2'h0}, {wbuf_q, sh_q}};
								ptr_d    = ptr_inc;
							end
						end
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						if (nxt_q == ST_TX) begin
							oe_d  = ~pre_q[31];
							tx_d  = {pre_q[30:0], 1'b0};
							cnt_d = 4'h1;
						end else begin
							oe_d  = 1'b0;
							cnt_d = 4'h0;
						end
						st_d = nxt_q;
					end
				end
				ST_TX: begin
					if (scl_fall) begin
						if (cnt_q == `ISR_BYTE_BITS) begin
							oe_d   = 1'b0;
							mack_d = 1'b0;
							st_d   = ST_MACK;
						end else begin
							oe_d  = ~tx_q[31];
							tx_d  = {tx_q[30:0], 1'b0};
							cnt_d = cnt_q + 4'h1;
						end
					end
				end
				ST_MACK: begin
					if (scl_rise) begin
						mack_d = ~sda_s_q;
					end else if (scl_fall) begin
						if (last_byte) begin
							req_fire = 1'b1;
							req_d    = '{ISR_OP_COMMIT, {ptr_q, 2'h0}, 32'h0000_0000};
							if (mack_q || burst_q) begin
								ptr_d = ptr_inc;
							end
						end
						if (!mack_q) begin
							st_d = ST_IGN;
						end else begin
							st_d   = ST_TX;
							cnt_d  = 4'h1;
							bidx_d = bidx_q + 2'h1;
							if (last_byte) begin
								burst_d = 1'b1;
								oe_d    = ~pre_q[31];
								tx_d    = {pre_q[30:0], 1'b0};
							end else begin
								oe_d = ~tx_q[31];
								tx_d = {tx_q[30:0], 1'b0};
								if (bidx_q == 2'h2) begin
									req_fire = 1'b1;
									req_d    = '{ISR_OP_READ, {ptr_inc, 2'h0}, 32'h0000_0000};
								end
							end
						end
					end
				end
			endcase
		end
	end

	// Sequencer registers, frozen while the enable is low
	always_ff @(posedge LINK_CLK or posedge lrst_q) begin
		if (lrst_q) begin
			st_q    <= ST_IDLE;
			nxt_q   <= ST_IDLE;
			cnt_q   <= 4'h0;
			bidx_q  <= 2'h0;
			sh_q    <= 8'h00;
			ptr_q   <= 8'h00;
			wbuf_q  <= 24'h00_0000;
			tx_q    <= 32'h0000_0000;
			mack_q  <= 1'b0;
			burst_q <= 1'b0;
			oe_q    <= 1'b0;
		end else if (ce_s_q) begin
			st_q    <= st_d;
			nxt_q   <= nxt_d;
			cnt_q   <= cnt_d;
			bidx_q  <= bidx_d;
			sh_q    <= sh_d;
			ptr_q   <= ptr_d;
			wbuf_q  <= wbuf_d;
			tx_q    <= tx_d;
			mack_q  <= mack_d;
			burst_q <= burst_d;
			oe_q    <= oe_d;
		end
	end

	// Request handshake and snapshot return; one access is in flight at a time
	always_ff @(posedge LINK_CLK or posedge lrst_q) begin
		if (lrst_q) begin
			req_q     <= '0;
			req_tgl_q <= 1'b0;
			pre_q     <= 32'h0000_0000;
			sda_o_q   <= 1'b0;
		end else if (ce_s_q) begin
			sda_o_q <= 1'b0;
			if (req_fire) begin
				req_q     <= req_d;
				req_tgl_q <= ~req_tgl_q;
			end
			if (ack_edge) begin
				pre_q <= rsp_q;
			end
		end
	end

	assign SDA_O  = sda_o_q;
	assign SDA_OE = oe_q;

	// ==========================================================
	// Link domain checks
	// ==========================================================
	property p_strap_gate;
		@(posedge LINK_CLK) disable iff (lrst_q)
		(!en_s_q && ce_s_q) |=> (!oe_q && st_q == ST_IDLE);
	endproperty
	a_strap_gate: assert property (p_strap_gate) else $error("port active without strap");

	property p_ctl_ack;
		@(posedge LINK_CLK) disable iff (lrst_q)
		(go && st_q == ST_CTL && byte_end && addr_hit) |=> (oe_q && st_q == ST_ACK);
	endproperty
	a_ctl_ack: assert property (p_ctl_ack) else $error("own address not acknowledged");

	property p_mismatch;
		@(posedge LINK_CLK) disable iff (lrst_q)
		(go && st_q == ST_CTL && byte_end && !addr_hit) |=> (st_q == ST_IGN && !oe_q);
	endproperty
	a_mismatch: assert property (p_mismatch) else $error("foreign address not ignored");

	property p_idx_ptr;
		@(posedge LINK_CLK) disable iff (lrst_q)
		(go && st_q == ST_IDX && byte_end) |=> (ptr_q == $past(sh_q) && oe_q);
	endproperty
	a_idx_ptr: assert property (p_idx_ptr) else $error("index not loaded");

	property p_stop;
		@(posedge LINK_CLK) disable iff (lrst_q)
		(bus_stop && en_s_q && ce_s_q) |=> (st_q == ST_IDLE && !oe_q);
	endproperty
	a_stop: assert property (p_stop) else $error("stop did not end the transfer");

	property p_early_nack;
		@(posedge LINK_CLK) disable iff (lrst_q)
		(go && st_q == ST_MACK && scl_fall && !mack_q && !last_byte) |=>
			(st_q == ST_IGN && !oe_q && req_tgl_q == $past(req_tgl_q));
	endproperty
	a_early_nack: assert property (p_early_nack) else $error("early nack not honoured");

	property p_msb_first;
		@(posedge LINK_CLK) disable iff (lrst_q)
		(go && st_q == ST_TX && scl_fall && cnt_q != `ISR_BYTE_BITS) |=> (oe_q == !$past(tx_q[31]));
	endproperty
	a_msb_first: assert property (p_msb_first) else $error("bit order wrong");

	property p_burst_inc;
		@(posedge LINK_CLK) disable iff (lrst_q)
		(go && st_q == ST_MACK && scl_fall && mack_q && last_byte) |=>
			(ptr_q == $past(ptr_q) + 8'h01 && req_q.op == ISR_OP_COMMIT);
	endproperty
	a_burst_inc: assert property (p_burst_inc) else $error("pointer not advanced");

	property p_write_full;
		@(posedge LINK_CLK) disable iff (lrst_q)
		(go && req_fire && req_d.op == ISR_OP_WRITE) |-> (last_byte && st_q == ST_WR);
	endproperty
	a_write_full: assert property (p_write_full) else $error("partial write issued");

	property p_ack_release;
		@(posedge LINK_CLK) disable iff (lrst_q)
		(go && st_q == ST_ACK && scl_fall && nxt_q != ST_TX) |=> !oe_q;
	endproperty
	a_ack_release: assert property (p_ack_release) else $error("acknowledge not released");
endmodule

`default_nettype wire

// file: tb/isr_host_model.sv
// Behavioural host that masters the serial link at the fast bus rate.
`timescale 1ns/100ps
`default_nettype none
// ====================
// Host model
module isr_host_model (
	input  wire logic dev_pull,
	output var  logic scl,
	output wire logic sda
);
	// Quarter of a 400 kHz bit time
	localparam time Q = 625ns;
	logic host_low;

	// Open drain with pull-up: the line is low while either side pulls
	assign sda = ~(host_low | dev_pull);

	// Idle bus: both lines released
	initial begin
		scl      = 1'b1;
		host_low = 1'b0;
	end

	// Start or repeated start; data moves a quarter after the clock fall so no false edge is seen
	task automatic start();
		#Q host_low = 1'b0;
		#Q scl = 1'b1;
		#Q host_low = 1'b1;
		#Q scl = 1'b0;
	endtask

	// Stop: data rises while the clock is high
	task automatic stop();
		#Q host_low = 1'b1;
		#Q scl = 1'b1;
		#Q host_low = 1'b0;
		#Q;
	endtask

	// Nine clocks msb first; a 1 releases the line, rx holds what the line showed
	task automatic byte_io(input logic [8:0] tx, output logic [8:0] rx);
		for (int i = 8; i >= 0; i--) begin
			#Q host_low = ~tx[i];
			#Q scl = 1'b1;
			#Q rx[i] = sda;
			#Q scl = 1'b0;
		end
	endtask
endmodule
`default_nettype wire

// file: tb/isr_top_tb.sv
// Self-checking bench for the serial register access slave.
`timescale 1ns/100ps
`default_nettype none
// ====================
// Bench
module isr_top_tb;
	import isr_pkg::*;
	// Ordinary case: write flag, index, data written, word expected back
	typedef struct packed {
		logic        wr;
		logic [7:0]  idx;
		logic [31:0] wdata;
		logic [31:0] exp;
	} isr_row_t;
	localparam isr_row_t ROWS [3] = '{
		'{1'b1, 8'h00, 32'h1234_5678, 32'h1234_5678},
		'{1'b1, 8'h7F, 32'hA5C3_0F96, 32'hA5C3_0F96},
		'{1'b0, 8'h90, 32'h0, 32'h0}};
	logic        ref_clk   = 1'b0;
	logic        link_clk  = 1'b0;
	logic        reset     = 1'b1;
	logic        reg_ack   = 1'b0;
	logic        reg_hit   = 1'b0;
	logic [1:0]  strap     = 2'h2;
	logic [31:0] reg_rdata = 32'h0;
	logic        sda_o, sda_oe, serial_active, reg_stb, scl, sda, ack;
	isr_req_t    reg_req;
	logic [31:0] mem [256];
	logic [31:0] w, last_wdata;
	logic [9:0]  last_addr;
	logic [8:0]  r9;
	int          failures = 0, samples_checked = 0, n_wr = 0, n_cm = 0, wr0, cm0;

	// Clocks; the link clock is offset so its edges never meet host or reference events
	always #12.5 ref_clk = ~ref_clk;
	initial begin
		#0.3;
		forever #16 link_clk = ~link_clk;
	end

	isr_top i_dut (
		.REF_CLK         (ref_clk),
		.RESET           (reset),
		.CLK_EN          (1'b1),
		.LINK_CLK        (link_clk),
		.MGMT_MODE_STRAP (strap),
		.SCL_I           (scl),
		.SDA_I           (sda),
		.SDA_O           (sda_o),
		.SDA_OE          (sda_oe),
		.SERIAL_ACTIVE   (serial_active),
		.REG_REQ         (reg_req),
		.REG_STB         (reg_stb),
		.REG_ACK         (reg_ack),
		.REG_RDATA       (reg_rdata),
		.REG_HIT         (reg_hit)
	);
	isr_host_model i_host (
		.dev_pull (sda_oe & ~sda_o),
		.scl      (scl),
		.sda      (sda)
	);

	// Register side answers the cycle after each strobe; indices from 80h up are unused
	always @(negedge ref_clk) begin
		reg_ack <= reg_stb;
		if (reg_stb) begin
			reg_hit   <= reg_req.addr[9:2] < 8'h80;
			reg_rdata <= mem[reg_req.addr[9:2]];
			if (reg_req.op === ISR_OP_COMMIT) n_cm++;
			if (reg_req.op === ISR_OP_WRITE) begin
				n_wr++;
				last_wdata = reg_req.wdata;
				last_addr  = reg_req.addr;
				if (reg_req.addr[9:2] < 8'h80) mem[reg_req.addr[9:2]] = reg_req.wdata;
			end
		end
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	task automatic put(input logic [7:0] b, output logic a);
		logic [8:0] r;
		i_host.byte_io({b, 1'b1}, r);
		a = ~r[0];
	endtask

	// Four bytes; the last one is acknowledged only when another register should follow
	task automatic rd_word(input logic more, output logic [31:0] d);
		logic [8:0] r;
		for (int k = 0; k < 4; k++) begin
			i_host.byte_io({8'hFF, ~(more || k < 3)}, r);
			d = {d[23:0], r[8:1]};
		end
	endtask

	task automatic rd_ptr(output logic [31:0] d);
		i_host.start();
		put(8'h15, ack);
		chk("read control ack", 1, ack);
		rd_word(1'b0, d);
		i_host.stop();
	endtask

	// Point at an index, then turn round with a repeated start: no data is written
	task automatic rd_at(input logic [7:0] idx, output logic [31:0] d);
		i_host.start();
		put(8'h14, ack);
		chk("control ack", 1, ack);
		put(idx, ack);
		chk("index ack", 1, ack);
		rd_ptr(d);
	endtask

	task automatic wr_reg(input logic [7:0] idx, input logic [31:0] d);
		i_host.start();
		put(8'h14, ack);
		put(idx, ack);
		for (int k = 3; k >= 0; k--) begin
			put(d[8*k +: 8], ack);
			chk("data ack", 1, ack);
		end
		i_host.stop();
	endtask

	// A hang is cut short and counted
	initial begin
		#2_300_000;
		failures++;
		conclude();
	end

	// Main sequence
	initial begin
		for (int i = 0; i < 256; i++) mem[i] = {4{i[7:0]}};
		repeat (20) @(negedge ref_clk);
		reset = 1'b0;
		repeat (20) @(negedge ref_clk);
		chk("active", 1, serial_active);
		foreach (ROWS[i]) begin
			wr0 = n_wr;
			if (ROWS[i].wr) begin
				wr_reg(ROWS[i].idx, ROWS[i].wdata);
				chk("write address", {ROWS[i].idx, 2'b00}, last_addr);
				chk("write data", ROWS[i].wdata, last_wdata);
				wr0++;
			end
			cm0 = n_cm;
			rd_at(ROWS[i].idx, w);
			chk("write count", wr0, n_wr);
			chk("read data", ROWS[i].exp, w);
			chk("commit", cm0 + 1, n_cm);
		end
		// Foreign address, then bytes with no start in between
		wr0 = n_wr;
		i_host.start();
		put(8'h16, ack);
		chk("foreign ack", 0, ack);
		put(8'h14, ack);
		chk("ignored ack", 0, ack);
		i_host.stop();
		// Write cut short, then a pointer-only write closed by stop
		i_host.start();
		put(8'h14, ack);
		put(8'h02, ack);
		put(8'hAA, ack);
		put(8'h55, ack);
		i_host.stop();
		i_host.start();
		put(8'h14, ack);
		put(8'hFF, ack);
		i_host.stop();
		chk("dropped write", wr0, n_wr);
		// Burst across the wrap of the pointer
		cm0 = n_cm;
		i_host.start();
		put(8'h15, ack);
		rd_word(1'b1, w);
		chk("burst first", 32'h0, w);
		rd_word(1'b0, w);
		chk("burst wrapped", 32'h1234_5678, w);
		i_host.stop();
		chk("burst commits", cm0 + 2, n_cm);
		rd_ptr(w);
		chk("after burst", 32'h0101_0101, w);
		rd_ptr(w);
		chk("after single", 32'h0101_0101, w);
		// Early nack, then an unexpected start in mid-read
		cm0 = n_cm;
		i_host.start();
		put(8'h15, ack);
		i_host.byte_io(9'h1FE, r9);
		i_host.byte_io(9'h1FF, r9);
		i_host.byte_io(9'h1FF, r9);
		chk("line released", 9'h1FF, r9);
		i_host.stop();
		// Point at a word whose second byte starts with a 1, so the line is free for the restart
		i_host.start();
		put(8'h14, ack);
		put(8'h7F, ack);
		i_host.start();
		put(8'h15, ack);
		i_host.byte_io(9'h1FE, r9);
		i_host.start();
		put(8'h14, ack);
		chk("restart ack", 1, ack);
		put(8'h03, ack);
		i_host.stop();
		chk("no commit", cm0, n_cm);
		// Second reset with the strap off
		@(negedge ref_clk);
		strap = 2'h1;
		reset = 1'b1;
		repeat (20) @(negedge ref_clk);
		reset = 1'b0;
		repeat (20) @(negedge ref_clk);
		chk("inactive", 0, serial_active);
		i_host.start();
		put(8'h14, ack);
		chk("strap off ack", 0, ack);
		i_host.stop();
		conclude();
	end
endmodule
`default_nettype wire
